// >>> inc/spr_if.sv
// Purpose: Serial link between the printer receiver and the host port.
// Assumes: All four lines idle at mark.
// Notes: Each line has a single driver, so no enables are needed.
`timescale 1ns/100ps
interface spr_if;
    logic rxd;
    logic txd;
    logic dtr;
    logic dsr;
    modport dev(input rxd, input dsr, output txd, output dtr);
    modport host(output rxd, output dsr, input txd, input dtr);
endinterface

// >>> inc/spr_pkg.sv
// Purpose: Types and helper functions shared by both link ends.
// Assumes: The constants header is on the include path.
// Notes: Frames are shifted out least significant bit first.
`include "spr_regs.svh"
package spr_pkg;
    typedef logic [`SPR_CNT_W-1:0] spr_cnt_t;

    typedef enum logic [4:0] {
        RX_IDLE = 5'h01,
        RX_HALF = 5'h02,
        RX_DATA = 5'h04,
        RX_PAR = 5'h08,
        RX_STOP = 5'h10
    } spr_rx_st_t;

    typedef enum logic [1:0] {
        TX_IDLE = 2'h1,
        TX_SHIFT = 2'h2
    } spr_tx_st_t;

    // Clock cycles in one bit time for rate select 0 (150 bps) to 7.
    function automatic spr_cnt_t spr_bit_cycles(int clk_hz, logic [2:0] sel);
        spr_cnt_t c;
        c = '0;
        for (int i = 0; i < 8; i++) begin
            if (sel == 3'(i)) begin
                c = spr_cnt_t'(clk_hz / (`SPR_BASE_BPS << i));
            end
        end
        return c;
    endfunction

    // Start, data, optional parity and stop bits, LSB first.
    function automatic logic [11:0] spr_frame(logic [7:0] d, logic seven,
                                              logic par_en, logic odd);
        logic [11:0] f;
        logic p;
        p = (seven ? ^d[6:0] : ^d) ^ odd;
        f = {3'h7, (seven ? {1'b1, d[6:0]} : d), 1'b0};
        if (par_en) begin
            if (seven) begin
                f[8] = p;
            end else begin
                f[9] = p;
            end
        end
        return f;
    endfunction

    function automatic logic [3:0] spr_frame_len(logic seven, logic par_en);
        return (seven ? 4'h9 : 4'hA) + {3'h0, par_en};
    endfunction
endpackage

// >>> inc/spr_regs.svh
// Purpose: Shared constants of the serial print receiver and its host end.
// Assumes: Mark is logic one, space is logic zero on every line.
// Notes: Bit timing is derived from the clock rate at elaboration.
`ifndef SPR_REGS_SVH
`define SPR_REGS_SVH
`define SPR_CLK_HZ 10000000
`define SPR_BASE_BPS 150
`define SPR_MARK 1'b1
`define SPR_SPACE 1'b0
`define SPR_QMARK 8'h3F
`define SPR_XON 8'h11
`define SPR_XOFF 8'h13
`define SPR_BUF_SMALL 13'h0048
`define SPR_BUF_LARGE 13'h1000
`define SPR_STOP_SMALL 13'h000A
`define SPR_STOP_LARGE 13'h0080
`define SPR_RES_SMALL 13'h0014
`define SPR_RES_LARGE 13'h0100
`define SPR_FIFO_DEPTH 32
`define SPR_CNT_W 17
`endif

// >>> verification/serial_print_receiver_tb.sv
// Purpose: Self-checking bench for both link ends joined back to back.
// Assumes: A 1 MHz timing base at 19200 bps gives 52 clocks a bit.
// Notes: A queue model predicts every byte reaching the input buffer.
`timescale 1ns/100ps
module serial_print_receiver_tb;
    logic clk = 1'b0, srst = 1'b1, seven = 1'b0, par = 1'b0, odd = 1'b0;
    logic xon = 1'b0, busy = 1'b0, sv = 1'b0, allow = 1'b0, snd = 1'b0;
    logic stb = 1'b0, big = 1'b0;
    logic [2:0] rate = 3'h7;
    logic bufr = 1'b0, hold = 1'b0, bv, sack, sent, rv, rerr, xok, ep, ef, eo;
    logic [7:0] sd = 8'h00, stat = 8'h00, td, e, bd, rd;
    logic [7:0] exq[$], rq[$];
    int fail_count = 0, checks_done = 0, cyc = 0, nerr = 0, novr = 0;
    spr_if link();
    spr_device #(.CLK_HZ(1000000)) spr_device_inst (
        .clk(clk), .srst(srst), .link(link), .cfg_seven(seven),
        .cfg_par_en(par), .cfg_par_odd(odd), .cfg_xon_mode(xon),
        .cfg_big_buf(big), .cfg_rate(rate), .selftest_busy(stb),
        .online_busy(busy), .stat_valid(sv), .stat_data(stat),
        .stat_ack(sack), .buf_valid(bv), .buf_ready(bufr), .buf_data(bd),
        .err_parity(ep), .err_frame(ef), .err_overrun(eo));
    spr_host #(.CLK_HZ(1000000)) spr_host_inst (
        .clk(clk), .srst(srst), .link(link), .cfg_seven(seven),
        .cfg_par_en(par), .cfg_par_odd(odd), .cfg_xon_mode(xon),
        .cfg_rate(rate), .send_valid(snd), .send_data(sd), .send_ack(sent),
        .stat_allow(allow), .recv_valid(rv), .recv_data(rd),
        .recv_err(rerr), .xon_ok(xok));
    spr_link_chk #(.BIT(52)) spr_link_chk_inst (.clk(clk), .srst(srst),
        .rxd(link.rxd), .txd(link.txd), .dtr(link.dtr), .dsr(link.dsr));
    always #50 clk = ~clk;
    task automatic test_done();
        $display("checks %0d mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    task automatic chk(string n, logic [7:0] x, logic [7:0] g);
        checks_done++;
        if (g !== x) begin
            fail_count++;
            $display("ERROR %s expected %h seen %h", n, x, g);
        end
    endtask
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 60000) begin
            fail_count++;
            test_done();
        end
        if (!srst && bv === 1'b1 && bufr) begin
            e = exq.pop_front();
            chk("buf_data", e, bd);
        end
        if (rv === 1'b1)
            rq.push_back(rd);
        if (ep === 1'b1 || ef === 1'b1)
            nerr++;
        if (eo === 1'b1)
            novr++;
        if (sack === 1'b1)
            sv <= 1'b0;
        bufr <= !hold && $urandom_range(1, 0);
    end
    task automatic start(logic s, logic p, logic x);
        srst <= 1'b1;
        seven <= s;
        par <= p;
        xon <= x;
        odd <= $urandom_range(1, 0);
        big <= $urandom_range(1, 0);
        repeat (10) @(posedge clk);
        srst <= 1'b0;
        rq.delete();
        nerr = 0;
        novr = 0;
        repeat (3) @(posedge clk);
    endtask
    task automatic send(logic [7:0] b, logic [7:0] x);
        int n;
        n = 0;
        snd <= 1'b1;
        sd <= b;
        exq.push_back(x);
        do @(posedge clk); while (sent !== 1'b1 && ++n < 3000);
        snd <= 1'b0;
        @(posedge clk);
    endtask
    task automatic drain();
        int n;
        n = 0;
        hold <= 1'b0;
        while (exq.size() > 0 && n++ < 3000) @(posedge clk);
        chk("left", 8'h00, 8'(exq.size()));
    endtask
    initial begin
        void'($urandom(4933));
        for (int i = 0; i < 4; i++) begin
            start(i[0], i[1], 1'b0);
            for (int j = 0; j < 3; j++) begin
                td = 8'($urandom);
                send(td, i[0] ? {1'b0, td[6:0]} : td);
            end
            drain();
            chk("errors", 8'h00, 8'(nerr));
            $display("frame format test %0d done", i);
        end
        for (int i = 0; i < 2; i++) begin
            start(1'b0, 1'b0, i[0]);
            stat <= 8'($urandom) | 8'h20;
            sv <= 1'b1;
            repeat (600) @(posedge clk);
            chk("held", 8'(i), 8'(rq.size()));
            allow <= !i[0];
            repeat (1400) @(posedge clk);
            if (i == 1)
                chk("xon", 8'h11, rq[0]);
            chk("status", stat, rq[i]);
            $display("status test %0d done", i);
        end
        stb <= 1'b1;
        repeat (3) @(posedge clk);
        chk("selftest", 8'h01, {7'h00, link.dtr});
        stb <= 1'b0;
        busy <= 1'b1;
        repeat (3) @(posedge clk);
        chk("dtr", 8'h01, {7'h00, link.dtr});
        send(8'h41, 8'h3F);
        drain();
        chk("overrun", 8'h01, 8'(novr));
        busy <= 1'b0;
        $display("overrun test done");
        start(1'b0, 1'b0, 1'b0);
        hold <= 1'b1;
        for (int j = 0; j < 32; j++)
            send(8'(j + 7), 8'(j + 7));
        repeat (600) @(posedge clk);
        chk("full", 8'h01, {7'h00, link.dtr});
        drain();
        $display("fill test done");
        test_done();
    end
endmodule

// >>> verification/spr_link_chk.sv
// Purpose: Line timing checks on the link between both ends.
// Assumes: BIT is the bit time in clocks.
// Notes: Run counters measure low and high stretches of the rxd and txd lines.
`timescale 1ns/100ps
module spr_link_chk #(
    parameter int BIT = 52
) (
    // Clock and reset.
    input wire logic clk,
    input wire logic srst,
    // Link lines.
    input wire logic rxd,
    input wire logic txd,
    input wire logic dtr,
    input wire logic dsr
);
    logic [15:0] tl_reg, th_reg, rl_reg, rh_reg;
    always_ff @(posedge clk) begin
        tl_reg <= (srst || txd) ? 16'h0000 : tl_reg + 16'h0001;
        rl_reg <= (srst || rxd) ? 16'h0000 : rl_reg + 16'h0001;
        if (srst) begin
            th_reg <= 16'hFFFF;
        end else if (!txd) begin
            th_reg <= 16'h0000;
        end else if (th_reg != 16'hFFFF) begin
            th_reg <= th_reg + 16'h0001;
        end
        if (srst) begin
            rh_reg <= 16'hFFFF;
        end else if (!rxd) begin
            rh_reg <= 16'h0000;
        end else if (rh_reg != 16'hFFFF) begin
            rh_reg <= rh_reg + 16'h0001;
        end
    end
    default clocking @(posedge clk); endclocking
    default disable iff (srst);
    AST_DEV_RESET: assert property ($fell(srst) |-> txd && dtr)
        else $error("printer end not idle and busy after reset");
    AST_HOST_RESET: assert property ($fell(srst) |-> rxd && dsr)
        else $error("host end not at mark after reset");
    AST_TX_RUN: assert property ($rose(txd) |-> tl_reg % BIT == 0)
        else $error("txd low run not whole bits");
    AST_TX_STOP: assert property (tl_reg <= 10 * BIT)
        else $error("txd low past stop position");
    AST_TX_GAP: assert property ($fell(txd) |-> th_reg >= BIT)
        else $error("txd high run shorter than a bit");
    AST_RX_RUN: assert property ($rose(rxd) |-> rl_reg % BIT == 0)
        else $error("rxd low run not whole bits");
    AST_RX_STOP: assert property (rl_reg <= 10 * BIT)
        else $error("rxd low past stop position");
    AST_RX_GAP: assert property ($fell(rxd) |-> rh_reg >= BIT)
        else $error("rxd high run shorter than a bit");
    cover property ($fell(txd));
    cover property ($fell(rxd));
    cover property ($rose(dtr));
endmodule

// >>> verilog/spr_device.sv
// Purpose: Printer end: serial receiver, input buffer, flow and status send.
// Assumes: Printer side drains the buffer; host keeps the frame format.
// Notes: Errored or overrun characters enter the buffer as a question mark when it has room.
`timescale 1ns/100ps
`include "spr_regs.svh"
module spr_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = `SPR_FIFO_DEPTH
) (
    // Clock and reset.
    input wire logic clk,
    input wire logic srst,
    // Filling side.
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    // Draining side.
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data,
    output logic [$clog2(DEPTH):0] count
);
    localparam int PW = $clog2(DEPTH);
    typedef struct packed {
        logic [PW-1:0] wp;
        logic [PW-1:0] rp;
        logic [PW:0] cnt;
    } spr_fifo_state_t;

    spr_fifo_state_t s;
    spr_fifo_state_t n;
    logic [WIDTH-1:0] mem [DEPTH];
    logic push;
    logic pop;

    initial begin
        if (DEPTH < 2 || (1 << PW) != DEPTH) begin
            $error("spr_fifo: DEPTH must be a power of two, at least 2");
        end
    end

    assign in_ready = (s.cnt != (PW+1)'(DEPTH));
    assign out_valid = (s.cnt != '0);
    assign out_data = mem[s.rp];
    assign count = s.cnt;
    assign push = in_valid & in_ready;
    assign pop = out_valid & out_ready;

    always_comb begin
        n = s;
        if (push) begin
            n.wp = s.wp + 1'b1;
        end
        if (pop) begin
            n.rp = s.rp + 1'b1;
        end
        n.cnt = s.cnt + (PW+1)'(push) - (PW+1)'(pop);
        if (srst) begin
            n = '0;
        end
    end

    always_ff @(posedge clk) begin
        s <= n;
        if (push) begin
            mem[s.wp] <= in_data;
        end
    end
endmodule

// Function
// - Host idles receive line at mark
// - Errored characters stored as question mark
// - Characters arriving while busy flagged overrun
// - Reception continues during printing
// - Busy at reset, self-test, on-line
// - Send stop code at low free space
// - Send resume code when space recovers
// - Hardware mode: status waits for DSR space
// - Software mode: status ignores DSR
// - Start bit rechecked at half bit
// - Bits sampled one bit time apart
// - LSB first, parity after data
// - Space at stop bit is framing error
// - Parity checked only when enabled
// - DTR space ready, mark busy
// - Host obeys resume and stop codes
// - Frame: start, 7/8 data, parity, stop
// - Eight selectable rates 150 to 19200
// - Buffer size selects flow thresholds
module spr_device #(
    parameter int CLK_HZ = `SPR_CLK_HZ,
    parameter int FIFO_DEPTH = `SPR_FIFO_DEPTH
) (
    // Clock and reset.
    input wire logic clk,
    input wire logic srst,
    // Serial link.
    spr_if.dev link,
    // Configuration levels.
    input wire logic cfg_seven,
    input wire logic cfg_par_en,
    input wire logic cfg_par_odd,
    input wire logic cfg_xon_mode,
    input wire logic cfg_big_buf,
    input wire logic [2:0] cfg_rate,
    // Printer-side busy causes.
    input wire logic selftest_busy,
    input wire logic online_busy,
    // Status byte to send to the host.
    input wire logic stat_valid,
    input wire logic [7:0] stat_data,
    output logic stat_ack,
    // Input buffer drain.
    output logic buf_valid,
    input wire logic buf_ready,
    output logic [7:0] buf_data,
    // Error pulses.
    output logic err_parity,
    output logic err_frame,
    output logic err_overrun
);
    typedef struct packed {
        logic [1:0] rx_sync;
        logic [1:0] dsr_sync;
        spr_pkg::spr_rx_st_t rx_st;
        spr_pkg::spr_cnt_t rx_cnt;
        logic [3:0] rx_bit;
        logic [7:0] rx_sh;
        logic rx_par;
        spr_pkg::spr_tx_st_t tx_st;
        spr_pkg::spr_cnt_t tx_cnt;
        logic [3:0] tx_bit;
        logic [11:0] tx_sh;
        logic txd;
        logic dtr;
        logic busy;
        logic hold;
        logic pend_xon;
        logic pend_xoff;
        logic wr_valid;
        logic [7:0] wr_data;
        logic stat_ack;
        logic err_par;
        logic err_frm;
        logic err_ovr;
    } spr_dev_state_t;

    localparam int CW = $clog2(FIFO_DEPTH) + 1;

    spr_dev_state_t s;
    spr_dev_state_t n;
    logic fifo_in_ready;
    logic [CW-1:0] fifo_count;

    initial begin
        if (CLK_HZ / `SPR_BASE_BPS >= (1 << `SPR_CNT_W)
            || CLK_HZ / (`SPR_BASE_BPS << 7) < 4) begin
            $error("spr_device: CLK_HZ out of range for bit timing");
        end
        if (FIFO_DEPTH > 4096) begin
            $error("spr_device: FIFO_DEPTH above 4096");
        end
    end

    // Reception never waits on printing or on buffer space.
    spr_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_fifo (
        .clk(clk),
        .srst(srst),
        .in_valid(s.wr_valid),
        .in_ready(fifo_in_ready),
        .in_data(s.wr_data),
        .out_valid(buf_valid),
        .out_ready(buf_ready),
        .out_data(buf_data),
        .count(fifo_count)
    );

    always_comb begin
        spr_pkg::spr_cnt_t full;
        spr_pkg::spr_cnt_t half;
        logic line;
        logic ferr;
        logic perr;
        logic [7:0] rdata;
        logic [12:0] cap;
        logic [12:0] occ;
        logic [12:0] free;
        logic ld;
        logic [7:0] ld_data;
        logic [11:0] frame;
        full = spr_pkg::spr_bit_cycles(CLK_HZ, cfg_rate);
        half = full >> 1;
        line = s.rx_sync[1];
        ferr = 1'b0;
        perr = 1'b0;
        rdata = cfg_seven ? {1'b0, s.rx_sh[7:1]} : s.rx_sh;
        ld = 1'b0;
        ld_data = `SPR_XON;
        n = s;
        n.rx_sync = {s.rx_sync[0], link.rxd};
        n.dsr_sync = {s.dsr_sync[0], link.dsr};
        n.wr_valid = 1'b0;
        n.stat_ack = 1'b0;
        n.err_par = 1'b0;
        n.err_frm = 1'b0;
        n.err_ovr = 1'b0;
        case (s.rx_st)
            spr_pkg::RX_IDLE: begin
                if (line == `SPR_SPACE) begin
                    n.rx_st = spr_pkg::RX_HALF;
                    n.rx_cnt = half - 1'b1;
                end
            end
            spr_pkg::RX_HALF: begin
                if (s.rx_cnt != '0) begin
                    n.rx_cnt = s.rx_cnt - 1'b1;
                end else if (line == `SPR_SPACE) begin
                    n.rx_st = spr_pkg::RX_DATA;
                    n.rx_cnt = full - 1'b1;
                    n.rx_bit = 4'h0;
                    n.rx_par = 1'b0;
                end else begin
                    n.rx_st = spr_pkg::RX_IDLE;
                end
            end
            spr_pkg::RX_DATA: begin
                if (s.rx_cnt != '0) begin
                    n.rx_cnt = s.rx_cnt - 1'b1;
                end else begin
                    n.rx_sh = {line, s.rx_sh[7:1]};
                    n.rx_par = s.rx_par ^ line;
                    n.rx_cnt = full - 1'b1;
                    n.rx_bit = s.rx_bit + 1'b1;
                    if (s.rx_bit == (cfg_seven ? 4'h6 : 4'h7)) begin
                        n.rx_st = cfg_par_en ? spr_pkg::RX_PAR
                                             : spr_pkg::RX_STOP;
                    end
                end
            end
            spr_pkg::RX_PAR: begin
                if (s.rx_cnt != '0) begin
                    n.rx_cnt = s.rx_cnt - 1'b1;
                end else begin
                    n.rx_par = s.rx_par ^ line;
                    n.rx_cnt = full - 1'b1;
                    n.rx_st = spr_pkg::RX_STOP;
                end
            end
            spr_pkg::RX_STOP: begin
                if (s.rx_cnt != '0) begin
                    n.rx_cnt = s.rx_cnt - 1'b1;
                end else begin
                    ferr = (line == `SPR_SPACE);
                    perr = cfg_par_en & (s.rx_par ^ cfg_par_odd);
                    n.err_frm = ferr;
                    n.err_par = perr;
                    n.err_ovr = s.busy;
                    n.rx_st = spr_pkg::RX_IDLE;
                    // With no room at all the character is lost.
                    if (fifo_in_ready) begin
                        n.wr_valid = 1'b1;
                        n.wr_data = (ferr | perr | s.busy) ? `SPR_QMARK
                                                           : rdata;
                    end
                end
            end
            default: begin
                n.rx_st = spr_pkg::RX_IDLE;
            end
        endcase

        case (s.tx_st)
            spr_pkg::TX_IDLE: begin
                if (cfg_xon_mode & s.pend_xoff) begin
                    ld = 1'b1;
                    ld_data = `SPR_XOFF;
                    n.pend_xoff = 1'b0;
                end else if (cfg_xon_mode & s.pend_xon) begin
                    ld = 1'b1;
                    n.pend_xon = 1'b0;
                end else if (stat_valid & (cfg_xon_mode
                             | s.dsr_sync[1] == `SPR_SPACE)) begin
                    ld = 1'b1;
                    ld_data = stat_data;
                    n.stat_ack = 1'b1;
                end
            end
            spr_pkg::TX_SHIFT: begin
                if (s.tx_cnt != '0) begin
                    n.tx_cnt = s.tx_cnt - 1'b1;
                end else if (s.tx_bit == 4'h1) begin
                    n.tx_st = spr_pkg::TX_IDLE;
                    n.txd = `SPR_MARK;
                end else begin
                    n.tx_sh = {1'b1, s.tx_sh[11:1]};
                    n.txd = s.tx_sh[1];
                    n.tx_bit = s.tx_bit - 1'b1;
                    n.tx_cnt = full - 1'b1;
                end
            end
            default: begin
                n.tx_st = spr_pkg::TX_IDLE;
            end
        endcase
        frame = spr_pkg::spr_frame(ld_data, cfg_seven, cfg_par_en, cfg_par_odd);
        if (ld) begin
            n.tx_st = spr_pkg::TX_SHIFT;
            n.tx_sh = frame;
            n.txd = frame[0];
            n.tx_bit = spr_pkg::spr_frame_len(cfg_seven, cfg_par_en);
            n.tx_cnt = full - 1'b1;
        end

        // Free space is measured against the selected buffer size.
        cap = cfg_big_buf ? `SPR_BUF_LARGE : `SPR_BUF_SMALL;
        occ = 13'(fifo_count);
        free = (cap > occ) ? cap - occ : 13'h0000;
        if (free <= (cfg_big_buf ? `SPR_STOP_LARGE : `SPR_STOP_SMALL)) begin
            n.hold = 1'b1;
        end else if (free > (cfg_big_buf ? `SPR_RES_LARGE
                                         : `SPR_RES_SMALL)) begin
            n.hold = 1'b0;
        end
        if (!cfg_xon_mode) begin
            n.pend_xon = 1'b0;
            n.pend_xoff = 1'b0;
        end else if (n.hold & !s.hold) begin
            n.pend_xoff = 1'b1;
            n.pend_xon = 1'b0;
        end else if (!n.hold & s.hold) begin
            n.pend_xon = 1'b1;
            n.pend_xoff = 1'b0;
        end
        n.busy = n.hold | selftest_busy | online_busy | !fifo_in_ready;
        n.dtr = n.busy ? `SPR_MARK : `SPR_SPACE;

        if (srst) begin
            n = '0;
            n.rx_sync = 2'h3;
            n.dsr_sync = 2'h3;
            n.rx_st = spr_pkg::RX_IDLE;
            n.tx_st = spr_pkg::TX_IDLE;
            n.txd = `SPR_MARK;
            n.dtr = `SPR_MARK;
            n.busy = 1'b1;
            n.pend_xon = 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        s <= n;
    end

    assign link.txd = s.txd;
    assign link.dtr = s.dtr;
    assign stat_ack = s.stat_ack;
    assign err_parity = s.err_par;
    assign err_frame = s.err_frm;
    assign err_overrun = s.err_ovr;
endmodule

// >>> verilog/spr_host.sv
// Purpose: Host end: sends characters under flow control, receives status.
// Assumes: Same frame format and rate as the printer end.
// Notes: Flow control is checked only before a character starts.
`timescale 1ns/100ps
`include "spr_regs.svh"
module spr_host #(
    parameter int CLK_HZ = `SPR_CLK_HZ
) (
    // Clock and reset.
    input wire logic clk,
    input wire logic srst,
    // Serial link.
    spr_if.host link,
    // Configuration levels.
    input wire logic cfg_seven,
    input wire logic cfg_par_en,
    input wire logic cfg_par_odd,
    input wire logic cfg_xon_mode,
    input wire logic [2:0] cfg_rate,
    // Characters to send.
    input wire logic send_valid,
    input wire logic [7:0] send_data,
    output logic send_ack,
    // Status ready level shown on DSR.
    input wire logic stat_allow,
    // Received bytes.
    output logic recv_valid,
    output logic [7:0] recv_data,
    output logic recv_err,
    output logic xon_ok
);
    typedef struct packed {
        logic [1:0] rx_sync;
        logic [1:0] dtr_sync;
        spr_pkg::spr_rx_st_t rx_st;
        spr_pkg::spr_cnt_t rx_cnt;
        logic [3:0] rx_bit;
        logic [7:0] rx_sh;
        logic rx_par;
        spr_pkg::spr_tx_st_t tx_st;
        spr_pkg::spr_cnt_t tx_cnt;
        logic [3:0] tx_bit;
        logic [11:0] tx_sh;
        logic txd;
        logic dsr;
        logic xon_ok;
        logic send_ack;
        logic recv_valid;
        logic [7:0] recv_data;
        logic recv_err;
    } spr_host_state_t;

    spr_host_state_t s;
    spr_host_state_t n;

    initial begin
        if (CLK_HZ / `SPR_BASE_BPS >= (1 << `SPR_CNT_W)
            || CLK_HZ / (`SPR_BASE_BPS << 7) < 4) begin
            $error("spr_host: CLK_HZ out of range for bit timing");
        end
    end

    always_comb begin
        spr_pkg::spr_cnt_t full;
        logic line;
        logic [7:0] rdata;
        logic [11:0] frame;
        logic can_send;
        full = spr_pkg::spr_bit_cycles(CLK_HZ, cfg_rate);
        line = s.rx_sync[1];
        rdata = cfg_seven ? {1'b0, s.rx_sh[7:1]} : s.rx_sh;
        frame = spr_pkg::spr_frame(send_data, cfg_seven, cfg_par_en, cfg_par_odd);
        can_send = cfg_xon_mode ? s.xon_ok
                                : (s.dtr_sync[1] == `SPR_SPACE);
        n = s;
        n.rx_sync = {s.rx_sync[0], link.txd};
        n.dtr_sync = {s.dtr_sync[0], link.dtr};
        n.send_ack = 1'b0;
        n.recv_valid = 1'b0;
        n.dsr = stat_allow ? `SPR_SPACE : `SPR_MARK;
        case (s.rx_st)
            spr_pkg::RX_IDLE: begin
                if (line == `SPR_SPACE) begin
                    n.rx_st = spr_pkg::RX_HALF;
                    n.rx_cnt = (full >> 1) - 1'b1;
                end
            end
            spr_pkg::RX_HALF: begin
                if (s.rx_cnt != '0) begin
                    n.rx_cnt = s.rx_cnt - 1'b1;
                end else begin
                    n.rx_st = line ? spr_pkg::RX_IDLE : spr_pkg::RX_DATA;
                    n.rx_cnt = full - 1'b1;
                    n.rx_bit = 4'h0;
                    n.rx_par = 1'b0;
                end
            end
            spr_pkg::RX_DATA: begin
                if (s.rx_cnt != '0) begin
                    n.rx_cnt = s.rx_cnt - 1'b1;
                end else begin
                    n.rx_sh = {line, s.rx_sh[7:1]};
                    n.rx_par = s.rx_par ^ line;
                    n.rx_cnt = full - 1'b1;
                    n.rx_bit = s.rx_bit + 1'b1;
                    if (s.rx_bit == (cfg_seven ? 4'h6 : 4'h7)) begin
                        n.rx_st = cfg_par_en ? spr_pkg::RX_PAR
                                             : spr_pkg::RX_STOP;
                    end
                end
            end
            spr_pkg::RX_PAR: begin
                if (s.rx_cnt != '0) begin
                    n.rx_cnt = s.rx_cnt - 1'b1;
                end else begin
                    n.rx_par = s.rx_par ^ line;
                    n.rx_cnt = full - 1'b1;
                    n.rx_st = spr_pkg::RX_STOP;
                end
            end
            spr_pkg::RX_STOP: begin
                if (s.rx_cnt != '0) begin
                    n.rx_cnt = s.rx_cnt - 1'b1;
                end else begin
                    n.rx_st = spr_pkg::RX_IDLE;
                    n.recv_valid = 1'b1;
                    n.recv_data = rdata;
                    n.recv_err = (line == `SPR_SPACE)
                                 | (cfg_par_en & (s.rx_par ^ cfg_par_odd));
                    if (rdata == `SPR_XON) begin
                        n.xon_ok = 1'b1;
                    end else if (rdata == `SPR_XOFF) begin
                        n.xon_ok = 1'b0;
                    end
                end
            end
            default: begin
                n.rx_st = spr_pkg::RX_IDLE;
            end
        endcase
        case (s.tx_st)
            spr_pkg::TX_IDLE: begin
                if (send_valid & can_send) begin
                    n.tx_st = spr_pkg::TX_SHIFT;
                    n.tx_sh = frame;
                    n.txd = frame[0];
                    n.tx_bit = spr_pkg::spr_frame_len(cfg_seven, cfg_par_en);
                    n.tx_cnt = full - 1'b1;
                    n.send_ack = 1'b1;
                end
            end
            spr_pkg::TX_SHIFT: begin
                if (s.tx_cnt != '0) begin
                    n.tx_cnt = s.tx_cnt - 1'b1;
                end else if (s.tx_bit == 4'h1) begin
                    n.tx_st = spr_pkg::TX_IDLE;
                    n.txd = `SPR_MARK;
                end else begin
                    n.tx_sh = {1'b1, s.tx_sh[11:1]};
                    n.txd = s.tx_sh[1];
                    n.tx_bit = s.tx_bit - 1'b1;
                    n.tx_cnt = full - 1'b1;
                end
            end
            default: begin
                n.tx_st = spr_pkg::TX_IDLE;
            end
        endcase
        if (srst) begin
            n = '0;
            n.rx_sync = 2'h3;
            n.dtr_sync = 2'h3;
            n.rx_st = spr_pkg::RX_IDLE;
            n.tx_st = spr_pkg::TX_IDLE;
            n.txd = `SPR_MARK;
            n.dsr = `SPR_MARK;
        end
    end

    always_ff @(posedge clk) begin
        s <= n;
    end

    assign link.rxd = s.txd;
    assign link.dsr = s.dsr;
    assign send_ack = s.send_ack;
    assign recv_valid = s.recv_valid;
    assign recv_data = s.recv_data;
    assign recv_err = s.recv_err;
    assign xon_ok = s.xon_ok;
endmodule
